// ### pkg/drg_cfg.svh
// Operation
// - single-rate gearing on the primary clock only for link clocks up to 250 MHz
// - double and quad gearing on the edge clock only above 250 MHz
// - single gearing takes one bit per edge, two-bit word per cycle
// - double gearing gives four bits per word, quad gearing gives eight bits
// - double gearing divides the edge clock by two for the word clock
// - quad gearing divides the edge clock by four for the word clock
// - fixed data delay cancels clock injection before the capture register
// - optional run-time data delay may override the default delay
// - interface type selects the default delay of both data delays
// - centered clock unshifted; edge-aligned clock shifted by the loop code
// - master loop makes a 90-degree code, slave delay applies it
// - in edge-aligned builds the slave output is the loop's reference
// - after reset no slave code update until the loop reports lock
// - after lock the slave loads first, then the loop hold is released
// - edge-aligned builds may offset the loop delay at run time
// - centered edge builds sequence gate stop against capture and divider reset
// - move steps one tap, direction low up, high down; load restores
`ifndef DRG_CFG_SVH
`define DRG_CFG_SVH
`define DRG_X1_FMAX_MHZ 250
`define DRG_A_CTRL 4'h0
`define DRG_A_ADJ 4'h4
`define DRG_A_STAT 4'h8
`define DRG_A_CODE 4'hc
`define DRG_CB_DYN 0
`define DRG_CB_SADJ 1
`define DRG_CB_MARG 2
`define DRG_CF_MOFS 15:8
`define DRG_AB_DMOVE 0
`define DRG_AB_DDIR 1
`define DRG_AB_DLOAD_N 2
`define DRG_AB_SMOVE 3
`define DRG_AB_SDIR 4
`define DRG_AB_SLOAD_N 5
`define DRG_SB_OVR 3
`define DRG_CODE90 8'h40
`define DRG_CODE_MAX 8'hff
`define DRG_TAP_MAX 8'h7f
`define DRG_LOCK_CYC 64
`define DRG_SKEW_CYC 8
`define DRG_DLY_X1C 7'h10
`define DRG_DLY_X1A 7'h20
`define DRG_DLY_X2C 7'h10
`define DRG_DLY_X2A 7'h20
`define DRG_DLY_X4C 7'h10
`define DRG_DLY_X4A 7'h20
`define DRG_FIFO_DEPTH 32
`endif

// ### pkg/drg_pkg.sv
package drg_pkg;
    typedef enum logic [2:0] {
        SQ_RST = 3'h0,
        SQ_WAIT = 3'h1,
        SQ_LOAD = 3'h3,
        SQ_REL = 3'h2,
        SQ_RUN = 3'h6
    } drg_seq_e;
    typedef enum logic [2:0] {
        IFT_X1C, IFT_X1A, IFT_X2C, IFT_X2A, IFT_X4C, IFT_X4A
    } drg_ift_e;
    // rise is the earlier bit and sits on top of every pair
    typedef struct packed {
        logic rise;
        logic fall;
    } drg_lane_s;
    typedef struct packed {
        logic [3:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } drg_bus_s;
    typedef struct packed {
        drg_seq_e seq;
        logic [7:0] wait_cnt;
        logic [15:0] hist;
        logic [7:0] shf;
        logic [1:0] div;
        logic [7:0] dll_cnt;
        logic dll_lock;
        logic freeze;
        logic [7:0] dll_code;
        logic [7:0] slv_code;
        logic slv_cout;
        logic [6:0] tap;
        logic stop;
        logic cap_rst;
        logic [2:0] ctrl;
        logic [7:0] margin;
        logic overrun;
        logic push;
        logic ready;
        logic [7:0] push_word;
        logic [31:0] rdata;
    } drg_state_s;
endpackage

// ### rtl/drg_fifo.sv
`timescale 1ns/1ps
module drg_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 32
) (
    input wire logic i_mclk, // clock
    input wire logic i_rst_b, // async reset, low
    input wire logic i_valid, // write valid
    input wire logic [W-1:0] i_data, // write word
    output logic o_in_ready, // room for a word
    output logic o_valid, // read word valid
    output logic [W-1:0] o_data, // read word
    input wire logic i_ready // reader takes word
);
    import drg_pkg::*;
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic rdy;
        logic ovld;
        logic [W-1:0] odat;
    } drg_fifo_s;
    drg_fifo_s q, d;
    logic push;
    logic pop;

    always_comb begin
        d = q;
        push = i_valid && q.rdy;
        pop = (q.cnt != '0) && (!q.ovld || i_ready);
        if (push) begin
            d.mem[q.wp] = i_data;
            d.wp = q.wp + AW'(1);
        end
        if (pop) begin
            d.odat = q.mem[q.rp];
            d.ovld = 1'b1;
            d.rp = q.rp + AW'(1);
        end else if (i_ready) begin
            d.ovld = 1'b0;
        end
        d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
        d.rdy = d.cnt != (AW+1)'(DEPTH);
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            q <= '0;
            q.rdy <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign o_in_ready = q.rdy;
    assign o_valid = q.ovld;
    assign o_data = q.odat;
endmodule

// ### rtl/drg_rx_front.sv
// Added by the designer: strobed register access and the address map.
`timescale 1ns/1ps
`include "drg_cfg.svh"
module drg_rx_front #(
    parameter int GEAR = 1,
    parameter bit ALIGNED = 1'b0,
    parameter bit DYN_DELAY = 1'b1,
    parameter int LINK_MHZ = 250,
    parameter int LOCK_CYC = `DRG_LOCK_CYC,
    parameter int SKEW_CYC = `DRG_SKEW_CYC,
    parameter int FIFO_DEPTH = `DRG_FIFO_DEPTH
) (
    input wire logic i_mclk, // link clock, up to 250 MHz single gearing, above 250 MHz double and quad
    input wire logic i_rst_b, // async reset, low
    input drg_pkg::drg_lane_s i_lane, // ddr bit pair this cycle
    input drg_pkg::drg_bus_s i_bus, // register port
    output logic [31:0] o_rdata, // read data, cycle after read
    output logic o_word_valid, // parallel word valid
    output logic [2*GEAR-1:0] o_word, // parallel word
    input wire logic i_word_ready, // fabric takes word
    output logic o_fifo_ready, // buffer has room
    output logic o_edge_stop, // edge clock gate stop
    output logic o_cap_rst, // capture and divider reset
    output logic o_dll_freeze, // loop code hold
    output logic o_dll_lock, // loop locked
    output logic [7:0] o_slave_code, // clock slave delay code
    output logic o_slave_cout, // slave delay at a limit
    output logic [6:0] o_data_tap, // data delay setting
    output logic o_ready // startup complete
);
    import drg_pkg::*;

    localparam int WORD_W = 2 * GEAR;
    localparam bit EDGE = GEAR > 1;
    // gearing choice must match the link rate, else startup never leaves reset
    localparam bit RATE_OK = EDGE ? (LINK_MHZ > `DRG_X1_FMAX_MHZ)
                                  : (LINK_MHZ <= `DRG_X1_FMAX_MHZ);
    localparam logic [7:0] SKEW_W = EDGE && !ALIGNED ? 8'(SKEW_CYC - 1) : 8'h00;
    localparam logic [7:0] LOCK_W = 8'(LOCK_CYC - 1);
    localparam logic [1:0] DIV_LAST = 2'(GEAR - 1);
    localparam drg_ift_e IFT = GEAR == 4 ? (ALIGNED ? IFT_X4A : IFT_X4C) :
                               GEAR == 2 ? (ALIGNED ? IFT_X2A : IFT_X2C) :
                               (ALIGNED ? IFT_X1A : IFT_X1C);

    drg_state_s q, d;
    logic fifo_rdy;
    logic fifo_vld;
    logic [WORD_W-1:0] fifo_dat;

    // default data delay per interface type
    function automatic logic [6:0] dflt_delay(input drg_ift_e t);
        case (t)
            IFT_X1C: dflt_delay = `DRG_DLY_X1C;
            IFT_X1A: dflt_delay = `DRG_DLY_X1A;
            IFT_X2C: dflt_delay = `DRG_DLY_X2C;
            IFT_X2A: dflt_delay = `DRG_DLY_X2A;
            IFT_X4C: dflt_delay = `DRG_DLY_X4C;
            IFT_X4A: dflt_delay = `DRG_DLY_X4A;
            default: dflt_delay = `DRG_DLY_X1C;
        endcase
    endfunction

    // one tap up or down, saturating at 0 and lim
    function automatic logic [8:0] tap_step(
        input logic [7:0] v,
        input logic dn,
        input logic [7:0] lim
    );
        if (!dn) begin
            tap_step = (v == lim) ? {1'b1, v} : {1'b0, v + 8'h01};
        end else begin
            tap_step = (v == 8'h00) ? {1'b1, v} : {1'b0, v - 8'h01};
        end
    endfunction

    localparam logic [6:0] DFLT = dflt_delay(IFT);

    logic wr_ctrl;
    logic wr_adj;
    logic wr_stat;
    logic dyn_on;
    logic sadj_on;
    logic [2:0] dsel;
    logic [1:0] pair;
    logic [8:0] stp;
    logic [7:0] base;
    logic [15:0] tapw;

    always_comb begin
        d = q;
        d.push = 1'b0;
        d.rdata = 32'h0;
        stp = 9'h0;
        tapw = 16'h0;
        base = `DRG_CODE90;
        wr_ctrl = i_bus.wr && (i_bus.addr == `DRG_A_CTRL);
        wr_adj = i_bus.wr && (i_bus.addr == `DRG_A_ADJ);
        wr_stat = i_bus.wr && (i_bus.addr == `DRG_A_STAT);
        dyn_on = DYN_DELAY && q.ctrl[`DRG_CB_DYN];
        sadj_on = ALIGNED && q.ctrl[`DRG_CB_SADJ];

        if (wr_ctrl) begin
            d.ctrl = i_bus.wdata[2:0];
            d.margin = i_bus.wdata[`DRG_CF_MOFS];
        end

        // startup sequencer
        case (q.seq)
            SQ_RST: begin
                if (RATE_OK) begin
                    d.seq = SQ_WAIT;
                    d.wait_cnt = 8'h00;
                end
            end
            SQ_WAIT: begin
                if (ALIGNED) begin
                    d.cap_rst = 1'b0;
                    d.stop = 1'b0;
                    if (q.dll_lock) begin
                        d.seq = SQ_LOAD;
                        d.freeze = 1'b1;
                    end
                end else if (q.wait_cnt >= SKEW_W) begin
                    d.seq = SQ_LOAD;
                    d.cap_rst = 1'b0;
                    d.wait_cnt = 8'h00;
                end else begin
                    d.wait_cnt = q.wait_cnt + 8'h01;
                end
            end
            SQ_LOAD: begin
                if (ALIGNED) begin
                    d.seq = SQ_REL;
                end else if (q.wait_cnt >= SKEW_W) begin
                    d.seq = SQ_REL;
                    d.stop = 1'b0;
                end else begin
                    d.wait_cnt = q.wait_cnt + 8'h01;
                end
            end
            SQ_REL: begin
                d.freeze = 1'b0;
                d.seq = SQ_RUN;
            end
            SQ_RUN: begin
                d.seq = SQ_RUN;
            end
            default: begin
                d.seq = SQ_RST;
            end
        endcase

        // master loop; reference is the slave output clock
        if (ALIGNED && !q.dll_lock) begin
            d.dll_cnt = q.dll_cnt + 8'h01;
            if (q.dll_cnt == LOCK_W) begin
                d.dll_lock = 1'b1;
            end
        end
        if (q.ctrl[`DRG_CB_MARG] && ALIGNED) begin
            base = `DRG_CODE90 + q.margin;
        end
        if (!q.freeze) begin
            d.dll_code = base;
        end

        // clock slave delay
        if (!ALIGNED) begin
            d.slv_code = 8'h00;
        end else if (q.seq == SQ_LOAD) begin
            d.slv_code = q.dll_code;
        end else if (q.seq == SQ_RUN) begin
            if (!sadj_on) begin
                d.slv_code = q.dll_code;
            end else if (wr_adj && !i_bus.wdata[`DRG_AB_SLOAD_N]) begin
                d.slv_code = q.dll_code;
                d.slv_cout = 1'b0;
            end else if (wr_adj && i_bus.wdata[`DRG_AB_SMOVE]) begin
                stp = tap_step(q.slv_code, i_bus.wdata[`DRG_AB_SDIR], `DRG_CODE_MAX);
                d.slv_code = stp[7:0];
                d.slv_cout = stp[8];
            end
        end

        // run-time data delay
        if (wr_adj && !i_bus.wdata[`DRG_AB_DLOAD_N]) begin
            d.tap = DFLT;
        end else if (wr_adj && dyn_on && i_bus.wdata[`DRG_AB_DMOVE]) begin
            stp = tap_step({1'b0, q.tap}, i_bus.wdata[`DRG_AB_DDIR], `DRG_TAP_MAX);
            d.tap = stp[6:0];
        end

        // data delay line ahead of capture
        d.hist = {q.hist[13:0], i_lane};
        dsel = dyn_on ? q.tap[6:4] : DFLT[6:4];
        pair = q.hist[{dsel, 1'b0} +: 2];

        // capture and word divider
        if (q.cap_rst) begin
            d.shf = 8'h00;
            d.div = 2'h0;
        end else begin
            d.shf = {q.shf[5:0], pair};
            if (q.div == DIV_LAST) begin
                d.div = 2'h0;
                d.push = q.seq == SQ_RUN;
                d.push_word = d.shf;
            end else begin
                d.div = q.div + 2'h1;
            end
        end

        // overrun: set beats clear
        if (wr_stat && i_bus.wdata[`DRG_SB_OVR]) begin
            d.overrun = 1'b0;
        end
        if (q.push && !fifo_rdy) begin
            d.overrun = 1'b1;
        end

        if (i_bus.rd) begin
            tapw = {q.dll_code, q.slv_code};
            case (i_bus.addr)
                `DRG_A_CTRL: d.rdata = {16'h0, q.margin, 5'h0, q.ctrl};
                `DRG_A_ADJ: d.rdata = 32'h0;
                `DRG_A_STAT: d.rdata = {17'h0, q.tap, 1'b0, q.seq,
                                        q.overrun, q.slv_cout,
                                        q.seq == SQ_RUN, q.dll_lock};
                `DRG_A_CODE: d.rdata = {16'h0, tapw};
                default: d.rdata = 32'h0;
            endcase
        end

        // registered copy of the run state for the ready pin
        d.ready = d.seq == SQ_RUN;
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            q <= '0;
            q.seq <= SQ_RST;
            q.stop <= 1'b1;
            q.cap_rst <= 1'b1;
            q.tap <= DFLT;
            q.dll_code <= `DRG_CODE90;
        end else begin
            q <= d;
        end
    end

    drg_fifo #(
        .W(WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_mclk(i_mclk),
        .i_rst_b(i_rst_b),
        .i_valid(q.push),
        .i_data(q.push_word[WORD_W-1:0]),
        .o_in_ready(fifo_rdy),
        .o_valid(fifo_vld),
        .o_data(fifo_dat),
        .i_ready(i_word_ready)
    );

    assign o_rdata = q.rdata;
    assign o_word_valid = fifo_vld;
    assign o_word = fifo_dat;
    assign o_fifo_ready = fifo_rdy;
    assign o_edge_stop = q.stop;
    assign o_cap_rst = q.cap_rst;
    assign o_dll_freeze = q.freeze;
    assign o_dll_lock = q.dll_lock;
    assign o_slave_code = q.slv_code;
    assign o_slave_cout = q.slv_cout;
    assign o_data_tap = q.tap;
    assign o_ready = q.ready;
endmodule

// ### sim/drg_rx_front_asserts.sv
`timescale 1ns/1ps
`include "drg_cfg.svh"
module drg_rx_front_asserts #(
    parameter int GEAR = 1
) (
    input wire logic i_mclk, // clock
    input wire logic i_rst_b, // async reset, low
    input drg_pkg::drg_bus_s i_bus, // register port
    input wire logic [31:0] o_rdata, // read data
    input wire logic o_word_valid, // word valid
    input wire logic [2*GEAR-1:0] o_word, // word
    input wire logic i_word_ready, // fabric takes word
    input wire logic o_fifo_ready, // buffer room
    input wire logic o_edge_stop, // gate stop
    input wire logic o_cap_rst, // capture reset
    input wire logic o_dll_freeze, // loop hold
    input wire logic o_dll_lock, // loop lock
    input wire logic [7:0] o_slave_code, // slave code
    input wire logic o_ready // startup done
);
    import drg_pkg::*;
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_b);

    lock_before_run_a: assert property (o_ready |-> o_dll_lock)
        else $error("run without lock");
    no_early_code_a: assert property (!o_dll_lock |-> o_slave_code == 8'h00)
        else $error("slave code moved before lock");
    freeze_after_lock_a: assert property (o_dll_freeze |-> o_dll_lock)
        else $error("hold without lock");
    release_after_load_a: assert property ($fell(o_dll_freeze) |-> o_slave_code == `DRG_CODE90)
        else $error("hold released before slave load");
    valid_after_run_a: assert property (o_word_valid |-> o_ready && !o_cap_rst)
        else $error("word valid before startup");
    word_holds_a: assert property (o_word_valid && !i_word_ready |=>
        o_word_valid && $stable(o_word))
        else $error("word changed before taken");
    clocks_run_a: assert property (o_ready |-> !o_edge_stop && !o_cap_rst)
        else $error("gate or capture held in run");
    rdata_idle_a: assert property (!$past(i_bus.rd) |-> o_rdata == 32'h0)
        else $error("read data outside read slot");
    lock_sticky_a: assert property (o_dll_lock |=> o_dll_lock [*2])
        else $error("lock dropped");
    full_has_word_a: assert property (!o_fifo_ready |-> o_word_valid)
        else $error("full buffer shows no word");

    cover property ($rose(o_ready));
    cover property ($fell(o_dll_freeze));
    cover property (!o_fifo_ready);
    cover property (o_word_valid && i_word_ready);
endmodule
bind drg_rx_front drg_rx_front_asserts #(.GEAR(GEAR)) u_chk (
    .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_bus(i_bus), .o_rdata(o_rdata),
    .o_word_valid(o_word_valid), .o_word(o_word), .i_word_ready(i_word_ready),
    .o_fifo_ready(o_fifo_ready), .o_edge_stop(o_edge_stop), .o_cap_rst(o_cap_rst),
    .o_dll_freeze(o_dll_freeze), .o_dll_lock(o_dll_lock),
    .o_slave_code(o_slave_code), .o_ready(o_ready)
);

// ### sim/drg_tx_model.sv
`timescale 1ns/1ps
module drg_tx_model (
    input wire logic i_mclk, // link clock, 250 MHz at most
    input wire logic i_rst_b, // async reset, low
    output drg_pkg::drg_lane_s o_lane // ddr bit pair
);
    import drg_pkg::*;
    logic [1:0] cnt_q;
    // counting pattern, rise bit is the high bit of each pair
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt_q <= 2'h0;
        end else begin
            cnt_q <= cnt_q + 2'h1;
        end
    end
    assign o_lane.rise = cnt_q[1];
    assign o_lane.fall = cnt_q[0];
endmodule

// ### sim/drg_rx_front_test.sv
`timescale 1ns/1ps
`include "drg_cfg.svh"
`define CHK(a, b) n_compared++; if ((a) !== (b)) begin n_mismatch++; $display("ERROR %0t mismatch", $time); end
module drg_rx_front_test;
    import drg_pkg::*;
    logic i_mclk = 1'b0;
    logic i_rst_b = 1'b0;
    drg_lane_s lane;
    drg_bus_s bus = '0;
    logic i_word_ready = 1'b1;
    logic [31:0] o_rdata;
    logic o_word_valid;
    logic [1:0] o_word;
    logic o_fifo_ready;
    logic [7:0] o_slave_code;
    logic [6:0] o_data_tap;
    logic o_ready;
    logic [31:0] d;
    logic [1:0] prev;
    logic have_prev = 1'b0;
    logic chk_on = 1'b0;
    int n_mismatch = 0;
    int n_compared = 0;
    always #2 i_mclk = ~i_mclk;
    drg_tx_model i_tx (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .o_lane(lane));
    drg_rx_front #(.GEAR(1), .ALIGNED(1'b1), .LOCK_CYC(4), .SKEW_CYC(2)) i_dut (
        .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_lane(lane), .i_bus(bus),
        .o_rdata(o_rdata), .o_word_valid(o_word_valid), .o_word(o_word),
        .i_word_ready(i_word_ready), .o_fifo_ready(o_fifo_ready), .o_edge_stop(),
        .o_cap_rst(), .o_dll_freeze(), .o_dll_lock(), .o_slave_code(o_slave_code),
        .o_slave_cout(), .o_data_tap(o_data_tap), .o_ready(o_ready)
    );
    task automatic bus_wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge i_mclk);
        bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge i_mclk);
        bus.wr <= 1'b0;
        @(posedge i_mclk);
    endtask
    task automatic bus_rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge i_mclk);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge i_mclk);
        bus.rd <= 1'b0;
        @(posedge i_mclk);
        v = o_rdata;
    endtask
    task automatic print_verdict;
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // words popped with no drop must count up by one
    always @(posedge i_mclk) begin
        if (chk_on && o_word_valid && i_word_ready) begin
            if (have_prev) begin
                `CHK(o_word, prev + 2'h1)
            end
            prev <= o_word;
            have_prev <= 1'b1;
        end
    end
    initial begin
        repeat (5000) @(posedge i_mclk);
        n_mismatch++;
        print_verdict();
    end
    initial begin
        repeat (16) @(posedge i_mclk);
        i_rst_b <= 1'b1;
        for (int i = 0; i < 200 && o_ready !== 1'b1; i++) @(posedge i_mclk);
        chk_on <= 1'b1;
        bus_rd(`DRG_A_STAT, d);
        `CHK(d[1:0], 2'h3)
        `CHK(d[6:4], SQ_RUN)
        `CHK(d[14:8], `DRG_DLY_X1A)
        bus_rd(`DRG_A_CODE, d);
        `CHK(d[15:0], {`DRG_CODE90, `DRG_CODE90})
        bus_rd(4'h2, d);
        `CHK(d, 32'h0)
        bus_wr(`DRG_A_CTRL, 32'h3);
        bus_wr(`DRG_A_ADJ, 32'h2d);
        `CHK(o_slave_code, `DRG_CODE90 + 8'h1)
        `CHK(o_data_tap, `DRG_DLY_X1A + 7'h1)
        bus_wr(`DRG_A_ADJ, 32'h3f);
        `CHK(o_slave_code, `DRG_CODE90)
        `CHK(o_data_tap, `DRG_DLY_X1A)
        bus_wr(`DRG_A_ADJ, 32'h2c);
        bus_wr(`DRG_A_ADJ, 32'h00);
        `CHK(o_slave_code, `DRG_CODE90)
        bus_wr(`DRG_A_CTRL, 32'h504);
        repeat (4) @(posedge i_mclk);
        bus_rd(`DRG_A_CODE, d);
        `CHK(d[15:0], 16'h4545)
        bus_wr(`DRG_A_CTRL, 32'h0);
        chk_on <= 1'b0;
        i_word_ready <= 1'b0;
        for (int i = 0; i < 100 && o_fifo_ready !== 1'b0; i++) @(posedge i_mclk);
        repeat (3) @(posedge i_mclk);
        `CHK(o_fifo_ready, 1'b0)
        bus_rd(`DRG_A_STAT, d);
        `CHK(d[`DRG_SB_OVR], 1'b1)
        i_word_ready <= 1'b1;
        repeat (40) @(posedge i_mclk);
        bus_wr(`DRG_A_STAT, 32'h8);
        bus_rd(`DRG_A_STAT, d);
        `CHK(d[`DRG_SB_OVR], 1'b0)
        `CHK(o_fifo_ready, 1'b1)
        print_verdict();
    end
endmodule
